// ### core/gpt_pkg.sv
/*
 * Shared constants of the general purpose timer: register offsets, field positions,
 * reset values, mode codes and the real-time-clock divide ratio.
 * Assumes a single 32-bit AHB-Lite slave port with word-aligned registers.
 */
`default_nettype none
package gpt_pkg;
	// Register byte offsets.
	localparam logic [11:0] OFF_CFG    = 12'h000;
	localparam logic [11:0] OFF_MODE_A = 12'h004;
	localparam logic [11:0] OFF_MODE_B = 12'h008;
	localparam logic [11:0] OFF_CTL    = 12'h00C;
	localparam logic [11:0] OFF_MASK   = 12'h018;
	localparam logic [11:0] OFF_RAW    = 12'h01C;
	localparam logic [11:0] OFF_MSKD   = 12'h020;
	localparam logic [11:0] OFF_CLR    = 12'h024;
	localparam logic [11:0] OFF_ILR_A  = 12'h028;
	localparam logic [11:0] OFF_ILR_B  = 12'h02C;
	localparam logic [11:0] OFF_MAT_A  = 12'h030;
	localparam logic [11:0] OFF_MAT_B  = 12'h034;
	localparam logic [11:0] OFF_PRE_A  = 12'h038;
	localparam logic [11:0] OFF_PRE_B  = 12'h03C;
	localparam logic [11:0] OFF_CNT_A  = 12'h048;
	localparam logic [11:0] OFF_CNT_B  = 12'h04C;
	// Global configuration codes.
	localparam logic [2:0] CFG_32BIT = 3'h0;
	localparam logic [2:0] CFG_RTC   = 3'h1;
	localparam logic [2:0] CFG_16BIT = 3'h4;
	// Timer function field codes and mode register bits.
	localparam logic [1:0] FN_ONESHOT  = 2'h1;
	localparam logic [1:0] FN_PERIODIC = 2'h2;
	localparam logic [1:0] FN_CAPTURE  = 2'h3;
	localparam int MODE_CAPKIND = 2;
	localparam int MODE_ALT     = 3;
	// Control register fields of one timer; timer B sits CTL_B_SHIFT bits higher.
	localparam int CTL_RUN     = 0;
	localparam int CTL_FREEZE  = 1;
	localparam int CTL_EVT     = 2;
	localparam int CTL_RTCEN   = 4;
	localparam int CTL_TRIG    = 5;
	localparam int CTL_INVERT  = 6;
	localparam int CTL_B_SHIFT = 8;
	localparam logic [15:0] CTL_WMASK = 16'h7F7F;
	// Event select codes.
	localparam logic [1:0] EVT_RISE = 2'h0;
	localparam logic [1:0] EVT_FALL = 2'h1;
	// Status flag bits of timer A; timer B flags sit FLG_B_SHIFT bits higher.
	localparam int FLG_TIMEOUT = 0;
	localparam int FLG_MATCH   = 1;
	localparam int FLG_CAPTURE = 2;
	localparam int FLG_RTC     = 3;
	localparam int FLG_B_SHIFT = 8;
	// Reset values.
	localparam logic [15:0] ILR_RESET = 16'hFFFF;
	localparam logic [15:0] MAT_RESET = 16'hFFFF;
	localparam logic [7:0]  PRE_RESET = 8'h00;
	// Last slow-clock divider value; 32768 edges per real-time-clock second.
	localparam logic [14:0] RTC_DIV_LAST = 15'h7FFF;
endpackage
`default_nettype wire

// ### core/gpt_timer.sv
/*
 * General purpose timer: two 16-bit down-counters, joinable into one 32-bit counter,
 * with one-shot, periodic, edge count, edge time, PWM and real-time-clock modes.
 * Assumes one AHB-Lite master, asynchronous capture pins, and a same-clock halt input.
 */
// Implementation choices: the register addresses and the AHB-Lite slave port.
// Contract
// - trigger pulse one clock wide at zero
// - interval load write reloads counter next cycle
// - freeze count while halt asserted and enabled
// - prescale stretches steps, 1 to 256 clocks
// - capture kind zero selects edge counting
// - each selected edge decrements count by one
// - count match sets raw and masked flags
// - after match reload, disable, ignore edges
// - edge time runs freely, no prescale
// - edge copies count, sets capture flag
// - edge time keeps running, reloads at zero
// - PWM needs alternate, edge count, periodic
// - PWM reloads at zero, sets no flags
// - PWM high at load value, low at match
// - invert bit inverts PWM output
// - configuration selects 32-bit, clock, or 16-bit
// - function field: one-shot or periodic
// - clock counter restarts from zero at match
// - writing one clears raw and masked flags
// - one-shot stops and clears enable at zero
// - timeout flag held until software clears
`timescale 1ns/100ps
`default_nettype none
module gpt_timer (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Capture/compare pins and halt request.
	input  wire logic [1:0]  capture_compare_pin,
	input  wire logic        halt_req,
	// Timer outputs.
	output logic      [1:0]  trigger_out,
	output logic      [1:0]  pwm_out
);
	// Bus address and data phase.
	logic        dph_wr_q;
	logic [11:0] dph_addr_q;
	logic [31:0] rdata_q;
	wire         aph_take = hsel && htrans[1] && hready;
	wire  [11:0] aph_addr = {haddr[11:2], 2'b00};

	// Registers.
	logic [2:0]  cfg_q;
	logic [3:0]  mode_q [2];
	logic [15:0] ctl_q;
	logic [15:0] mask_q;
	logic [15:0] raw_q;
	logic [15:0] ilr_q [2];
	logic [15:0] mat_q [2];
	logic [7:0]  psr_q [2];

	// Counter state.
	logic [15:0] cnt_q [2];
	logic [15:0] cnt_d [2];
	logic [7:0]  pre_q [2];
	logic [7:0]  pre_d [2];
	logic [15:0] cap_q [2];
	logic [15:0] cap_d [2];
	logic [1:0]  lvl_q;
	logic [1:0]  lvl_d;
	logic [14:0] rdiv_q;
	logic [14:0] rdiv_d;
	logic [1:0]  en_clr;
	logic [1:0]  to_ev;
	logic [1:0]  cm_ev;
	logic [1:0]  ce_ev;
	logic        rtc_ev;

	// Capture pin synchronisers and filtered levels.
	logic [1:0]  s1_q;
	logic [1:0]  s2_q;
	logic [1:0]  s3_q;
	logic [1:0]  flt_q;
	logic [1:0]  trig_q;
	logic [1:0]  pwm_q;

	// Write decode.
	wire w_cfg   = dph_wr_q && dph_addr_q == gpt_pkg::OFF_CFG;
	wire w_mode0 = dph_wr_q && dph_addr_q == gpt_pkg::OFF_MODE_A;
	wire w_mode1 = dph_wr_q && dph_addr_q == gpt_pkg::OFF_MODE_B;
	wire w_ctl   = dph_wr_q && dph_addr_q == gpt_pkg::OFF_CTL;
	wire w_mask  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_MASK;
	wire w_clr   = dph_wr_q && dph_addr_q == gpt_pkg::OFF_CLR;
	wire w_ilr0  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_ILR_A;
	wire w_ilr1  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_ILR_B;
	wire w_mat0  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_MAT_A;
	wire w_mat1  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_MAT_B;
	wire w_pre0  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_PRE_A;
	wire w_pre1  = dph_wr_q && dph_addr_q == gpt_pkg::OFF_PRE_B;

	// Global mode decode.
	wire m16 = cfg_q[2];
	wire m32 = cfg_q == gpt_pkg::CFG_32BIT;
	wire mrtc = cfg_q == gpt_pkg::CFG_RTC;
	wire [31:0] c32 = {cnt_q[1], cnt_q[0]};
	wire [31:0] ilr32 = {ilr_q[1], ilr_q[0]};
	wire [31:0] mat32 = {mat_q[1], mat_q[0]};
	wire rtc_start = w_ctl && mrtc && hwdata[gpt_pkg::CTL_RUN] && !ctl_q[gpt_pkg::CTL_RUN];

	// Edge detection on the filtered pin levels.
	wire [1:0] agree = ~(s2_q ^ s3_q);
	wire [1:0] rise = agree & s2_q & ~flt_q;
	wire [1:0] fall = agree & ~s2_q & flt_q;
	logic [1:0] ev_hit;
	logic [1:0] run;
	logic [1:0] fn [2];
	logic [1:0] evt [2];
	always_comb begin
		for (int n = 0; n < 2; n++) begin
			fn[n] = mode_q[n][1:0];
			evt[n] = ctl_q[n * gpt_pkg::CTL_B_SHIFT + gpt_pkg::CTL_EVT +: 2];
			ev_hit[n] = evt[n] == gpt_pkg::EVT_RISE ? rise[n] :
				evt[n] == gpt_pkg::EVT_FALL ? fall[n] : rise[n] | fall[n];
			run[n] = ctl_q[n * gpt_pkg::CTL_B_SHIFT + gpt_pkg::CTL_RUN] &&
				!(ctl_q[n * gpt_pkg::CTL_B_SHIFT + gpt_pkg::CTL_FREEZE] && halt_req);
		end
	end

	// Counter next-state logic.
	always_comb begin
		cnt_d = cnt_q;
		pre_d = pre_q;
		cap_d = cap_q;
		lvl_d = lvl_q;
		rdiv_d = rdiv_q;
		en_clr = 2'b00;
		to_ev = 2'b00;
		cm_ev = 2'b00;
		ce_ev = 2'b00;
		rtc_ev = 1'b0;
		if (m16) begin
			for (int n = 0; n < 2; n++) begin
				if (run[n]) begin
					if (mode_q[n][gpt_pkg::MODE_ALT] && !mode_q[n][gpt_pkg::MODE_CAPKIND] &&
						fn[n] == gpt_pkg::FN_PERIODIC) begin
						pre_d[n] = pre_q[n] == 8'h00 ? psr_q[n] : 8'(pre_q[n] - 8'h01);
						if (pre_q[n] == 8'h00) begin
							cnt_d[n] = cnt_q[n] == 16'h0000 ? ilr_q[n] : 16'(cnt_q[n] - 16'h0001);
						end
						if (cnt_q[n] == ilr_q[n]) begin
							lvl_d[n] = 1'b1;
						end else if (cnt_q[n] == mat_q[n]) begin
							lvl_d[n] = 1'b0;
						end
					end else if (fn[n] == gpt_pkg::FN_CAPTURE && !mode_q[n][gpt_pkg::MODE_CAPKIND]) begin
						if (ev_hit[n]) begin
							if (16'(cnt_q[n] - 16'h0001) == mat_q[n]) begin
								cm_ev[n] = 1'b1;
								cnt_d[n] = ilr_q[n];
								en_clr[n] = 1'b1;
							end else begin
								cnt_d[n] = 16'(cnt_q[n] - 16'h0001);
							end
						end
					end else if (fn[n] == gpt_pkg::FN_CAPTURE) begin
						cnt_d[n] = cnt_q[n] == 16'h0000 ? ilr_q[n] : 16'(cnt_q[n] - 16'h0001);
						if (ev_hit[n]) begin
							cap_d[n] = cnt_q[n];
							ce_ev[n] = 1'b1;
						end
					end else if (fn[n] == gpt_pkg::FN_ONESHOT || fn[n] == gpt_pkg::FN_PERIODIC) begin
						pre_d[n] = pre_q[n] == 8'h00 ? psr_q[n] : 8'(pre_q[n] - 8'h01);
						if (pre_q[n] == 8'h00) begin
							if (cnt_q[n] == 16'h0000) begin
								cnt_d[n] = ilr_q[n];
								to_ev[n] = 1'b1;
								en_clr[n] = fn[n] == gpt_pkg::FN_ONESHOT;
							end else begin
								cnt_d[n] = 16'(cnt_q[n] - 16'h0001);
							end
						end
					end
				end
			end
		end else if (m32) begin
			if (run[0]) begin
				if (c32 == 32'h0000_0000) begin
					{cnt_d[1], cnt_d[0]} = ilr32;
					to_ev[0] = 1'b1;
					en_clr[0] = fn[0] == gpt_pkg::FN_ONESHOT;
				end else begin
					{cnt_d[1], cnt_d[0]} = 32'(c32 - 32'h0000_0001);
				end
			end
		end else if (mrtc) begin
			if (ctl_q[gpt_pkg::CTL_RUN] && (ctl_q[gpt_pkg::CTL_RTCEN] || run[0]) && rise[0]) begin
				rdiv_d = rdiv_q == gpt_pkg::RTC_DIV_LAST ? 15'h0000 : 15'(rdiv_q + 15'h0001);
				if (rdiv_q == gpt_pkg::RTC_DIV_LAST) begin
					if (c32 == mat32) begin
						{cnt_d[1], cnt_d[0]} = 32'h0000_0000;
						rtc_ev = 1'b1;
					end else begin
						{cnt_d[1], cnt_d[0]} = 32'(c32 + 32'h0000_0001);
					end
				end
			end
		end
		if (w_ilr0) begin
			cnt_d[0] = hwdata[15:0];
			if (!m16) begin
				cnt_d[1] = hwdata[31:16];
			end
		end
		if (w_ilr1) begin
			cnt_d[1] = hwdata[15:0];
		end
		if (rtc_start) begin
			{cnt_d[1], cnt_d[0]} = 32'h0000_0001;
			rdiv_d = 15'h0000;
		end
	end

	// Status flag set terms; a set in the clearing cycle wins.
	wire [15:0] flg_set = {5'b0, ce_ev[1], cm_ev[1], to_ev[1], 4'b0, rtc_ev,
		ce_ev[0], cm_ev[0], to_ev[0]};
	wire [15:0] flg_clr = w_clr ? hwdata[15:0] : 16'h0000;
	wire [15:0] masked = raw_q & mask_q;

	// Read data selection.
	logic [31:0] rd_sel;
	always_comb begin
		case (aph_addr)
			gpt_pkg::OFF_CFG:    rd_sel = {29'h0, cfg_q};
			gpt_pkg::OFF_MODE_A: rd_sel = {28'h0, mode_q[0]};
			gpt_pkg::OFF_MODE_B: rd_sel = {28'h0, mode_q[1]};
			gpt_pkg::OFF_CTL:    rd_sel = {16'h0, ctl_q};
			gpt_pkg::OFF_MASK:   rd_sel = {16'h0, mask_q};
			gpt_pkg::OFF_RAW:    rd_sel = {16'h0, raw_q};
			gpt_pkg::OFF_MSKD:   rd_sel = {16'h0, masked};
			gpt_pkg::OFF_ILR_A:  rd_sel = m16 ? {16'h0, ilr_q[0]} : ilr32;
			gpt_pkg::OFF_ILR_B:  rd_sel = {16'h0, ilr_q[1]};
			gpt_pkg::OFF_MAT_A:  rd_sel = m16 ? {16'h0, mat_q[0]} : mat32;
			gpt_pkg::OFF_MAT_B:  rd_sel = {16'h0, mat_q[1]};
			gpt_pkg::OFF_PRE_A:  rd_sel = {24'h0, psr_q[0]};
			gpt_pkg::OFF_PRE_B:  rd_sel = {24'h0, psr_q[1]};
			gpt_pkg::OFF_CNT_A:  rd_sel = !m16 ? c32 : {16'h0, mode_q[0][gpt_pkg::MODE_CAPKIND] ?
				cap_q[0] : cnt_q[0]};
			gpt_pkg::OFF_CNT_B:  rd_sel = {16'h0, mode_q[1][gpt_pkg::MODE_CAPKIND] ?
				cap_q[1] : cnt_q[1]};
			default:             rd_sel = 32'h0000_0000;
		endcase
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign trigger_out = trig_q;
	assign pwm_out = pwm_q;

	// Bus phase registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dph_wr_q <= 1'b0;
			dph_addr_q <= 12'h000;
			rdata_q <= 32'h0000_0000;
		end else begin
			dph_wr_q <= aph_take && hwrite;
			dph_addr_q <= aph_addr;
			rdata_q <= aph_take && !hwrite ? rd_sel : 32'h0000_0000;
		end
	end

	// Software registers and flags.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= 3'h0;
			mode_q[0] <= 4'h0;
			mode_q[1] <= 4'h0;
			ctl_q <= 16'h0000;
			mask_q <= 16'h0000;
			raw_q <= 16'h0000;
			ilr_q[0] <= gpt_pkg::ILR_RESET;
			ilr_q[1] <= gpt_pkg::ILR_RESET;
			mat_q[0] <= gpt_pkg::MAT_RESET;
			mat_q[1] <= gpt_pkg::MAT_RESET;
			psr_q[0] <= gpt_pkg::PRE_RESET;
			psr_q[1] <= gpt_pkg::PRE_RESET;
		end else begin
			if (w_cfg) cfg_q <= hwdata[2:0];
			if (w_mode0) mode_q[0] <= hwdata[3:0];
			if (w_mode1) mode_q[1] <= hwdata[3:0];
			if (w_mask) mask_q <= hwdata[15:0];
			if (w_pre0) psr_q[0] <= hwdata[7:0];
			if (w_pre1) psr_q[1] <= hwdata[7:0];
			if (w_ilr0) ilr_q[0] <= hwdata[15:0];
			if (w_ilr1 || (w_ilr0 && !m16)) ilr_q[1] <= w_ilr1 ? hwdata[15:0] : hwdata[31:16];
			if (w_mat0) mat_q[0] <= hwdata[15:0];
			if (w_mat1 || (w_mat0 && !m16)) mat_q[1] <= w_mat1 ? hwdata[15:0] : hwdata[31:16];
			if (w_ctl) begin
				ctl_q <= hwdata[15:0] & gpt_pkg::CTL_WMASK;
			end else begin
				ctl_q[gpt_pkg::CTL_RUN] <= ctl_q[gpt_pkg::CTL_RUN] & ~en_clr[0];
				ctl_q[gpt_pkg::CTL_B_SHIFT] <= ctl_q[gpt_pkg::CTL_B_SHIFT] & ~en_clr[1];
			end
			raw_q <= (raw_q & ~flg_clr) | flg_set;
		end
	end

	// Counters, synchronisers and outputs.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q[0] <= gpt_pkg::ILR_RESET;
			cnt_q[1] <= gpt_pkg::ILR_RESET;
			pre_q[0] <= gpt_pkg::PRE_RESET;
			pre_q[1] <= gpt_pkg::PRE_RESET;
			cap_q[0] <= 16'h0000;
			cap_q[1] <= 16'h0000;
			lvl_q <= 2'b00;
			rdiv_q <= 15'h0000;
			s1_q <= 2'b00;
			s2_q <= 2'b00;
			s3_q <= 2'b00;
			flt_q <= 2'b00;
			trig_q <= 2'b00;
			pwm_q <= 2'b00;
		end else begin
			cnt_q <= cnt_d;
			pre_q <= pre_d;
			cap_q <= cap_d;
			lvl_q <= lvl_d;
			rdiv_q <= rdiv_d;
			s1_q <= capture_compare_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= (flt_q & ~agree) | (s2_q & agree);
			trig_q[0] <= to_ev[0] & ctl_q[gpt_pkg::CTL_TRIG];
			trig_q[1] <= to_ev[1] & ctl_q[gpt_pkg::CTL_B_SHIFT + gpt_pkg::CTL_TRIG];
			pwm_q[0] <= lvl_d[0] ^ ctl_q[gpt_pkg::CTL_INVERT];
			pwm_q[1] <= lvl_d[1] ^ ctl_q[gpt_pkg::CTL_B_SHIFT + gpt_pkg::CTL_INVERT];
		end
	end

	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire pwm1 = m16 && mode_q[1][gpt_pkg::MODE_ALT] && !mode_q[1][gpt_pkg::MODE_CAPKIND] &&
		fn[1] == gpt_pkg::FN_PERIODIC;
	chk_trig_pulse: assert property (trig_q[0] |-> $past(cnt_q[0]) == 16'h0000 && !$past(trig_q[0])
		|| !m16) else $error("trigger not tied to zero count");
	chk_ilr_reload: assert property (w_ilr0 && m16 |=> cnt_q[0] == $past(hwdata[15:0]))
		else $error("load write not taken");
	chk_freeze_hold: assert property (m16 && ctl_q[1] && halt_req && !w_ilr0 |=> $stable(cnt_q[0]))
		else $error("count moved while frozen");
	chk_prescale_wait: assert property (m16 && run[0] && fn[0] == gpt_pkg::FN_ONESHOT &&
		pre_q[0] != 8'h00 && !w_ilr0 |=> $stable(cnt_q[0]))
		else $error("step before prescale expired");
	chk_match_stop: assert property (cm_ev[1] && !w_ctl |=>
		raw_q[gpt_pkg::FLG_B_SHIFT + gpt_pkg::FLG_MATCH] && !ctl_q[gpt_pkg::CTL_B_SHIFT] &&
		cnt_q[1] == $past(ilr_q[1])) else $error("match did not stop");
	chk_capture_copy: assert property (ce_ev[0] |=> cap_q[0] == $past(cnt_q[0]) &&
		raw_q[gpt_pkg::FLG_CAPTURE]) else $error("capture not stored");
	chk_pwm_silent: assert property (pwm1 |-> !to_ev[1] && !cm_ev[1] && !ce_ev[1])
		else $error("flag event in pwm");
	chk_pwm_level: assert property (pwm1 && run[1] && cnt_q[1] == ilr_q[1] |=>
		pwm_q[1] == !$past(ctl_q[gpt_pkg::CTL_B_SHIFT + gpt_pkg::CTL_INVERT]))
		else $error("pwm level wrong");
	chk_flag_hold: assert property (raw_q[0] && !(w_clr && hwdata[0]) |=> raw_q[0])
		else $error("timeout flag lost");
	chk_flag_clear: assert property (w_clr && hwdata[0] && !to_ev[0] |=> !raw_q[0] && !masked[0])
		else $error("flag not cleared");
	chk_oneshot_stop: assert property (to_ev[0] && fn[0] == gpt_pkg::FN_ONESHOT && !w_ctl |=>
		!ctl_q[0]) else $error("one-shot kept running");
	cov_timeout: cover property (to_ev[0] ##1 trig_q[0]);
	cov_match: cover property (cm_ev[0]);
	cov_capture: cover property (ce_ev[0] ##[1:50] ce_ev[0]);
	cov_rtc: cover property (rtc_ev);
endmodule // gpt_timer
`default_nettype wire

// ### sim/gpt_pin_src.sv
/*
 * Capture pin source: drives both capture/compare pins of the timer with clean pulses.
 * Assumes the pins idle low and the bench clock paces every pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module gpt_pin_src (
	// Clock.
	input  wire logic       clk,
	// Capture/compare pins.
	output logic      [1:0] pin
);
	initial pin = 2'h0;
	// One pulse on pin b, high then low for w clocks each; w of 2 or more is seen.
	task automatic pulse(input int b, input int w);
		@(posedge clk);
		pin[b] <= 1'b1;
		repeat (w) @(posedge clk);
		pin[b] <= 1'b0;
		repeat (w) @(posedge clk);
	endtask
endmodule // gpt_pin_src
`default_nettype wire

// ### sim/tb.sv
/*
 * Self-checking bench of the general purpose timer.
 * Assumes the timer sits as the only AHB-Lite slave and the pin source drives its pins.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk, rst, hsel, hwrite, halt_req, hreadyout, hresp, dp_rd, peek;
	logic [31:0] haddr, hwdata, hrdata, lf, a, b, q_exp[$], q_msk[$];
	logic [1:0]  htrans, trigger_out, pwm_out, pin;
	logic [2:0]  hsize;
	logic [7:0]  pre;
	int          fail_count, cmp_count, cyc, hi, t, ilr, tcnt[2], tat[2], tper[2];
	localparam logic [31:0] M = 32'hFFFF_FFFF;

	gpt_timer u_gpt_timer (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .capture_compare_pin(pin), .halt_req(halt_req),
		.trigger_out(trigger_out), .pwm_out(pwm_out));
	gpt_pin_src u_gpt_pin_src (.clk(clk), .pin(pin));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic addr_ph(input logic [11:0] ad, input logic w);
		hsel <= 1'b1;
		haddr <= {20'h0, ad};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
	endtask

	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		addr_ph(ad, 1'b1);
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	// Notes the expected read data; the monitor compares it in the data phase.
	task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] m);
		q_exp.push_back(e);
		q_msk.push_back(m);
		addr_ph(ad, 1'b0);
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	task automatic rd_get(input logic [11:0] ad, output logic [31:0] v);
		peek <= 1'b1;
		addr_ph(ad, 1'b0);
		peek <= 1'b0;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		v = hrdata;
	endtask

	task automatic wait_pulse(input int i, input int n);
		int t0;
		t0 = tcnt[i];
		while (tcnt[i] < t0 + n) @(posedge clk);
	endtask

	task automatic count_hi(input int i, output int h);
		h = 0;
		repeat (40) begin
			@(posedge clk);
			h += (pwm_out[i] === 1'b1) ? 1 : 0;
		end
	endtask

	// Monitor: read data, trigger pulses and the run-time ceiling.
	always @(posedge clk) begin
		cyc++;
		if (dp_rd) begin
			chk("read data", q_exp.pop_front(), hrdata & q_msk.pop_front());
			chk("response", 32'h0, {31'h0, hresp});
		end
		dp_rd <= hsel & htrans[1] & ~hwrite & ~peek;
		for (int i = 0; i < 2; i++) begin
			if (trigger_out[i] === 1'b1) begin
				tcnt[i]++;
				tper[i] = cyc - tat[i];
				tat[i] = cyc;
			end
		end
		if (cyc >= 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		rst = 1'b1;
		{hsel, hwrite, halt_req, peek, dp_rd} = 5'h00;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		lf = 32'd80162;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(gpt_pkg::OFF_CFG, 32'h0, M);
		rd(gpt_pkg::OFF_CNT_B, 32'h0000_FFFF, M);
		wr(12'h040, M);
		rd(12'h040, 32'h0, M);
		wr(gpt_pkg::OFF_ILR_A, 32'h0001_0002);
		rd(gpt_pkg::OFF_ILR_A, 32'h0001_0002, M);
		rd(gpt_pkg::OFF_ILR_B, 32'h0000_0001, 32'h0000_FFFF);
		wr(gpt_pkg::OFF_CFG, 32'h4);
		lf = lfsr_next(lf);
		wr(gpt_pkg::OFF_ILR_B, {16'h0, lf[15:0]});
		rd(gpt_pkg::OFF_ILR_B, {16'h0, lf[15:0]}, 32'h0000_FFFF);
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			lf = lfsr_next(lf);
			pre = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : {4'h0, lf[3:0]};
			ilr = (k == 1) ? 1 : 9;
			wr(gpt_pkg::OFF_CTL, 32'h0);
			wr(gpt_pkg::OFF_MODE_A, 32'h2);
			wr(gpt_pkg::OFF_PRE_A, {24'h0, pre});
			wr(gpt_pkg::OFF_ILR_A, ilr);
			wr(gpt_pkg::OFF_CTL, 32'h21);
			wait_pulse(0, 2);
			chk("period", (ilr + 1) * (pre + 1), tper[0]);
		end
		wr(gpt_pkg::OFF_CTL, 32'h0);
		rd(gpt_pkg::OFF_RAW, 32'h1, 32'h1);
		wr(gpt_pkg::OFF_CLR, 32'h1);
		rd(gpt_pkg::OFF_RAW, 32'h0, 32'h1);
		wr(gpt_pkg::OFF_MODE_A, 32'h1);
		wr(gpt_pkg::OFF_PRE_A, 32'h0);
		wr(gpt_pkg::OFF_ILR_A, 32'h5);
		t = tcnt[0];
		wr(gpt_pkg::OFF_CTL, 32'h21);
		repeat (40) @(posedge clk);
		chk("one-shot pulses", t + 1, tcnt[0]);
		rd(gpt_pkg::OFF_CTL, 32'h0, 32'h1);
		rd(gpt_pkg::OFF_CNT_A, 32'h5, 32'h0000_FFFF);
		$display("test one-shot and periodic done");
		wr(gpt_pkg::OFF_MODE_A, 32'h2);
		wr(gpt_pkg::OFF_ILR_A, 32'h0000_FFFF);
		wr(gpt_pkg::OFF_CTL, 32'h1);
		wr(gpt_pkg::OFF_ILR_A, 32'h0000_0100);
		rd_get(gpt_pkg::OFF_CNT_A, a);
		chk("reload on write", 32'h1, {31'h0, a[15:0] <= 16'h0100});
		wr(gpt_pkg::OFF_CTL, 32'h3);
		halt_req <= 1'b1;
		rd_get(gpt_pkg::OFF_CNT_A, a);
		repeat (10) @(posedge clk);
		rd_get(gpt_pkg::OFF_CNT_A, b);
		chk("frozen count", a, b);
		halt_req <= 1'b0;
		repeat (10) @(posedge clk);
		rd_get(gpt_pkg::OFF_CNT_A, b);
		chk("resumed count", 32'h1, {31'h0, a !== b});
		$display("test reload and freeze done");
		for (int ev = 0; ev < 3; ev++) begin
			wr(gpt_pkg::OFF_CTL, 32'h0);
			wr(gpt_pkg::OFF_CLR, 32'h200);
			wr(gpt_pkg::OFF_MODE_B, 32'h3);
			wr(gpt_pkg::OFF_ILR_B, 32'hA);
			wr(gpt_pkg::OFF_MAT_B, 32'h8);
			wr(gpt_pkg::OFF_MASK, 32'h200);
			wr(gpt_pkg::OFF_CTL, 32'h100 | (ev << 10));
			u_gpt_pin_src.pulse(1, 4);
			repeat (5) @(posedge clk);
			rd(gpt_pkg::OFF_RAW, (ev == 2) ? 32'h200 : 32'h0, 32'h200);
			u_gpt_pin_src.pulse(1, 4);
			repeat (5) @(posedge clk);
			rd(gpt_pkg::OFF_RAW, 32'h200, 32'h200);
			rd(gpt_pkg::OFF_MSKD, 32'h200, 32'h200);
			u_gpt_pin_src.pulse(1, 4);
			repeat (5) @(posedge clk);
			rd(gpt_pkg::OFF_CNT_B, 32'hA, 32'h0000_FFFF);
			rd(gpt_pkg::OFF_CTL, 32'h0, 32'h100);
		end
		$display("test edge count done");
		wr(gpt_pkg::OFF_CTL, 32'h0);
		wr(gpt_pkg::OFF_MODE_A, 32'h7);
		wr(gpt_pkg::OFF_ILR_A, 32'h0000_FFFF);
		wr(gpt_pkg::OFF_MASK, 32'h4);
		wr(gpt_pkg::OFF_CTL, 32'h1);
		repeat (20) @(posedge clk);
		u_gpt_pin_src.pulse(0, 4);
		rd_get(gpt_pkg::OFF_CNT_A, a);
		repeat (20) @(posedge clk);
		rd_get(gpt_pkg::OFF_CNT_A, b);
		chk("captured held", a, b);
		chk("free run", 32'h1, {31'h0, a[15:0] < 16'hFFF0});
		rd(gpt_pkg::OFF_MSKD, 32'h4, 32'h4);
		u_gpt_pin_src.pulse(0, 4);
		rd_get(gpt_pkg::OFF_CNT_A, b);
		chk("recaptured", 32'h1, {31'h0, a !== b});
		$display("test edge time done");
		wr(gpt_pkg::OFF_CTL, 32'h0);
		wr(gpt_pkg::OFF_CLR, 32'h0F0F);
		wr(gpt_pkg::OFF_MODE_B, 32'hA);
		wr(gpt_pkg::OFF_ILR_B, 32'd19);
		wr(gpt_pkg::OFF_MAT_B, 32'd4);
		wr(gpt_pkg::OFF_PRE_B, 32'h0);
		wr(gpt_pkg::OFF_CTL, 32'h100);
		repeat (25) @(posedge clk);
		count_hi(1, hi);
		chk("pwm high", 32'd30, hi);
		rd(gpt_pkg::OFF_RAW, 32'h0, 32'h700);
		wr(gpt_pkg::OFF_CTL, 32'h0);
		wr(gpt_pkg::OFF_CTL, 32'h4100);
		repeat (25) @(posedge clk);
		count_hi(1, hi);
		chk("pwm inverted high", 32'd10, hi);
		$display("test pwm done");
		wr(gpt_pkg::OFF_CTL, 32'h0);
		wr(gpt_pkg::OFF_CFG, 32'h0);
		wr(gpt_pkg::OFF_CLR, 32'hFFFF);
		wr(gpt_pkg::OFF_MODE_A, 32'h1);
		wr(gpt_pkg::OFF_ILR_A, 32'h0000_0010);
		t = tcnt[0];
		wr(gpt_pkg::OFF_CTL, 32'h21);
		repeat (40) @(posedge clk);
		chk("32-bit pulses", t + 1, tcnt[0]);
		rd(gpt_pkg::OFF_CTL, 32'h0, 32'h1);
		rd(gpt_pkg::OFF_RAW, 32'h1, 32'h1);
		rd(gpt_pkg::OFF_CNT_A, 32'h0000_0010, M);
		wr(gpt_pkg::OFF_CTL, 32'h0);
		wr(gpt_pkg::OFF_CFG, 32'h1);
		wr(gpt_pkg::OFF_MAT_A, 32'h5);
		wr(gpt_pkg::OFF_CTL, 32'h1);
		u_gpt_pin_src.pulse(0, 4);
		rd(gpt_pkg::OFF_CNT_A, 32'h1, M);
		$display("test 32-bit and clock done");
		@(posedge clk);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
